// ### eprom_mode_and_security_control.sv
// Purpose: EPROM programming mode, normal-mode fetch port and security control.
// Assumes: All inputs are synchronous to clk_i; programming_voltage_pin_i is a high-voltage detector.
// Notes: The array and configuration bytes are nonvolatile and survive reset.
//
// How it works
// - Two modes only: programming mode and normal CPU running mode.
// - Programming mode exposes exactly 16 kbytes of array.
// - Erased bits read 1; programming only clears bits to 0.
// - Two configuration bytes live outside the user address space.
// - Config byte programs only when pointer and address select it.
// - Normal mode defaults to larger map; option selects smaller member.
// - Normal mode array is read-only with 16-bit fetches.
// - On-chip fetches insert one wait state.
// - External program select latched at reset release and held.
// - Programming mode only with high voltage on the programming pin.
// - Two-bit field selects one of four protection levels.
// - Level 3 is erased default with unrestricted access.
// - Level 2 blocks programming; reads stay unrestricted.
// - Level 1 blocks programming; array reads return encrypted data.
// - Runtime protection returns FF to operand reads from outside code.
// - Level 0 blocks programming; array reads give FF; runtime protection on.
// - Two config bits disable lower 8k array and upper 256 RAM bytes.
`timescale 1ns/100ps
module eprom_mode_and_security_control
    import eprom_ctrl_pkg::*;
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Mode pins.
    input wire logic programming_voltage_pin_i,
    input wire logic external_program_select_i,
    // Programmer port.
    input wire logic prog_write_i,
    input wire logic prog_read_i,
    input wire logic prog_cfg_space_i,
    input wire logic [EPROM_AW-1:0] prog_addr_i,
    input wire logic [7:0] prog_data_i,
    output logic [7:0] prog_rdata_o,
    output logic prog_rvalid_o,
    // CPU fetch port.
    input wire logic cpu_req_i,
    input wire logic [15:0] cpu_addr_i,
    input wire logic cpu_operand_i,
    input wire logic cpu_opcode_in_eprom_i,
    output logic [15:0] cpu_rdata_o,
    output logic cpu_ack_o,
    output logic cpu_hit_o,
    // Chip configuration outputs.
    output logic prog_mode_o,
    output logic external_program_o,
    output logic alt_family_o,
    output logic upper_ram_bank_enable_o,
    // Wishbone slave.
    input wire logic [3:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);

    logic [7:0] mem_reg [EPROM_BYTES];
    logic [7:0] cfg_low_reg;
    logic [7:0] cfg_high_reg;
    logic [2:0] config_byte_pointer_reg;
    logic [1:0] level_reg;
    logic loaded_reg;
    logic rst_d_reg;
    ctrl_state_t state_reg;
    logic [EPROM_AW-1:0] erase_idx_reg;
    logic [15:0] fetch_data_reg;
    logic fetch_hit_reg;
    logic erase_req_reg;
    logic reload_req_reg;
    policy_t policy;
    logic wb_req;
    logic prog_wr_go;
    logic prog_rd_go;
    logic cpu_go;
    logic cpu_in_rom;
    logic [EPROM_AW-1:0] word_lo;
    logic [7:0] prog_byte;

    security_policy u_policy
    (
        .level_i(level_reg),
        .policy_o(policy)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Request qualification.

    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign prog_wr_go = programming_voltage_pin_i && loaded_reg && state_reg == ST_IDLE
        && prog_write_i;
    assign prog_rd_go = programming_voltage_pin_i && loaded_reg && state_reg == ST_IDLE
        && prog_read_i && !prog_write_i;
    assign cpu_go = !programming_voltage_pin_i && loaded_reg && state_reg == ST_IDLE
        && cpu_req_i;
    assign cpu_in_rom = cpu_addr_i[15:14] == ROM_REGION && !external_program_o
        && (cpu_addr_i[13] || cfg_low_reg[CFG_ROM_BIT]);
    assign word_lo = {cpu_addr_i[13:1], 1'b0};

    always_comb
    begin
        prog_byte = mem_reg[prog_addr_i];
        unique case (policy.prog_read)
            RD_PLAIN: prog_byte = mem_reg[prog_addr_i];
            RD_ENCRYPTED: prog_byte = mem_reg[prog_addr_i] ^ ENCRYPT_KEY
                ^ prog_addr_i[7:0];
            RD_BLANK: prog_byte = ERASED_BYTE;
            default: prog_byte = ERASED_BYTE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer: security load, fetch wait state and erase sweep.

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_reg <= ST_LOAD;
            erase_idx_reg <= '0;
        end
        else
        begin
            unique case (state_reg)
                ST_LOAD: state_reg <= ST_IDLE;
                ST_IDLE:
                begin
                    if (erase_req_reg)
                    begin
                        state_reg <= ST_ERASE;
                        erase_idx_reg <= '0;
                    end
                    else if (reload_req_reg)
                        state_reg <= ST_LOAD;
                    else if (cpu_go)
                        state_reg <= ST_WAIT;
                end
                ST_WAIT: state_reg <= ST_IDLE;
                ST_ERASE:
                begin
                    erase_idx_reg <= erase_idx_reg + 1'b1;
                    if (&erase_idx_reg)
                        state_reg <= ST_LOAD;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            level_reg <= SEC_LEVEL0;
            loaded_reg <= 1'b0;
        end
        else if (state_reg == ST_LOAD)
        begin
            level_reg <= cfg_high_reg[CFG_SEC_LSB +: 2];
            loaded_reg <= 1'b1;
        end
        else if (state_reg == ST_ERASE)
            loaded_reg <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Nonvolatile array and configuration bytes.

    always_ff @(posedge clk_i)
    begin
        if (state_reg == ST_ERASE)
        begin
            mem_reg[erase_idx_reg] <= ERASED_BYTE;
            if (&erase_idx_reg)
            begin
                cfg_low_reg <= ERASED_BYTE;
                cfg_high_reg <= ERASED_BYTE;
            end
        end
        else if (prog_wr_go && policy.write_ok)
        begin
            if (!prog_cfg_space_i)
                mem_reg[prog_addr_i] <= mem_reg[prog_addr_i] & prog_data_i;
            else if (prog_addr_i == CFG_LOW_INDEX
                && config_byte_pointer_reg == CFG_LOW_INDEX[2:0])
                cfg_low_reg <= cfg_low_reg & prog_data_i;
            else if (prog_addr_i == CFG_HIGH_INDEX
                && config_byte_pointer_reg == CFG_HIGH_INDEX[2:0])
                cfg_high_reg <= cfg_high_reg & prog_data_i;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            config_byte_pointer_reg <= CFG_PTR_RESET;
        else if (prog_wr_go && prog_cfg_space_i && prog_addr_i == CFG_PTR_INDEX)
            config_byte_pointer_reg <= prog_data_i[2:0];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Programmer read path.

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            prog_rdata_o <= '0;
            prog_rvalid_o <= 1'b0;
        end
        else
        begin
            prog_rvalid_o <= prog_rd_go;
            if (prog_rd_go)
            begin
                if (!prog_cfg_space_i)
                    prog_rdata_o <= prog_byte;
                else if (prog_addr_i == CFG_LOW_INDEX)
                    prog_rdata_o <= cfg_low_reg;
                else if (prog_addr_i == CFG_HIGH_INDEX)
                    prog_rdata_o <= cfg_high_reg;
                else if (prog_addr_i == CFG_PTR_INDEX)
                    prog_rdata_o <= {5'h00, config_byte_pointer_reg};
                else
                    prog_rdata_o <= ERASED_BYTE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Normal mode fetch with one wait state.

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            fetch_data_reg <= '0;
            fetch_hit_reg <= 1'b0;
            cpu_rdata_o <= '0;
            cpu_ack_o <= 1'b0;
            cpu_hit_o <= 1'b0;
        end
        else
        begin
            if (cpu_go)
            begin
                fetch_hit_reg <= cpu_in_rom;
                if (!cpu_in_rom)
                    fetch_data_reg <= ERASED_WORD;
                else if (policy.runtime_protect && cpu_operand_i && !cpu_opcode_in_eprom_i)
                    fetch_data_reg <= ERASED_WORD;
                else
                    fetch_data_reg <= {mem_reg[word_lo | 14'h0001], mem_reg[word_lo]};
            end
            cpu_ack_o <= state_reg == ST_WAIT;
            if (state_reg == ST_WAIT)
            begin
                cpu_rdata_o <= fetch_data_reg;
                cpu_hit_o <= fetch_hit_reg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode outputs and reset-time strap.

    always_ff @(posedge clk_i)
    begin
        rst_d_reg <= rst_i;
        if (rst_d_reg && !rst_i)
            external_program_o <= external_program_select_i;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            prog_mode_o <= 1'b0;
            alt_family_o <= 1'b0;
            upper_ram_bank_enable_o <= 1'b1;
        end
        else
        begin
            prog_mode_o <= programming_voltage_pin_i;
            alt_family_o <= !cfg_low_reg[CFG_SMALL_BIT];
            upper_ram_bank_enable_o <= cfg_low_reg[CFG_RAM_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Wishbone slave.

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
            erase_req_reg <= 1'b0;
            reload_req_reg <= 1'b0;
        end
        else
        begin
            wb_ack_o <= wb_req;
            if (state_reg == ST_IDLE)
            begin
                erase_req_reg <= 1'b0;
                reload_req_reg <= 1'b0;
            end
            if (wb_req && wb_we_i && wb_adr_i == WB_CTRL_ADDR && wb_sel_i[0])
            begin
                if (wb_dat_i[CTRL_ERASE_BIT])
                    erase_req_reg <= 1'b1;
                if (wb_dat_i[CTRL_RELOAD_BIT])
                    reload_req_reg <= 1'b1;
            end
            if (wb_req && !wb_we_i)
            begin
                unique case (wb_adr_i)
                    WB_CTRL_ADDR: wb_dat_o <= {30'h0, reload_req_reg, erase_req_reg};
                    WB_STATUS_ADDR: wb_dat_o <= {24'h0, loaded_reg, state_reg,
                        level_reg, external_program_o, prog_mode_o, alt_family_o};
                    WB_CONFIG_ADDR: wb_dat_o <= {13'h0, config_byte_pointer_reg,
                        cfg_high_reg, cfg_low_reg};
                    default: wb_dat_o <= '0;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    logic [EPROM_AW-1:0] chk_addr_reg;
    logic [7:0] chk_exp_reg;
    logic chk_arm_reg;
    always_ff @(posedge clk_i)
    begin
        chk_arm_reg <= !rst_i && prog_wr_go && !prog_cfg_space_i;
        chk_addr_reg <= prog_addr_i;
        chk_exp_reg <= policy.write_ok ? (mem_reg[prog_addr_i] & prog_data_i)
            : mem_reg[prog_addr_i];
    end

    AST_CLEAR_ONLY: assert property (@(posedge clk_i) disable iff (rst_i)
        chk_arm_reg |-> mem_reg[chk_addr_reg] == chk_exp_reg)
        else $error("array write did not apply a pure bit clear");
    AST_LOCKED_NO_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
        prog_wr_go && !prog_cfg_space_i && level_reg != SEC_LEVEL3
        |=> mem_reg[chk_addr_reg] == $past(mem_reg[prog_addr_i]))
        else $error("array changed while write protected");
    AST_ONE_WAIT: assert property (@(posedge clk_i) disable iff (rst_i)
        cpu_go |=> !cpu_ack_o ##1 cpu_ack_o ##1 !cpu_ack_o)
        else $error("fetch answer not after exactly one wait state");
    AST_STRAP_HELD: assert property (@(posedge clk_i) disable iff (rst_i)
        !rst_d_reg && !$past(rst_d_reg) |-> $stable(external_program_o))
        else $error("external program select changed without reset");
    AST_VPP_ONLY: assert property (@(posedge clk_i) disable iff (rst_i)
        prog_rvalid_o |-> $past(programming_voltage_pin_i))
        else $error("programmer read served without high voltage");
    AST_LEVEL0_BLANK: assert property (@(posedge clk_i) disable iff (rst_i)
        prog_rd_go && !prog_cfg_space_i && level_reg == SEC_LEVEL0
        |=> prog_rdata_o == ERASED_BYTE)
        else $error("level 0 array read did not return FF");
    AST_RUNTIME_FF: assert property (@(posedge clk_i) disable iff (rst_i)
        cpu_go && level_reg <= SEC_LEVEL1 && cpu_operand_i && !cpu_opcode_in_eprom_i
        |-> ##2 cpu_rdata_o == ERASED_WORD)
        else $error("protected operand read leaked data");
    AST_POINTER_GUARD: assert property (@(posedge clk_i) disable iff (rst_i)
        prog_wr_go && prog_cfg_space_i && prog_addr_i == CFG_LOW_INDEX
        && config_byte_pointer_reg != CFG_LOW_INDEX[2:0] |=> $stable(cfg_low_reg))
        else $error("config byte written with mismatched pointer");
    AST_LOAD_FIRST: assert property (@(posedge clk_i) disable iff (rst_i)
        (prog_rvalid_o || cpu_ack_o) |-> loaded_reg)
        else $error("access served before security level load");

endmodule : eprom_mode_and_security_control

// ### eprom_ctrl_pkg.sv
// Purpose: Shared constants and types for the EPROM mode and security controller.
// Assumes: Wishbone offsets are byte addresses on a 32-bit data bus.
// Notes: Configuration bytes are kept in the controller, not in the user array.
package eprom_ctrl_pkg;

    // Array geometry.
    localparam int EPROM_BYTES = 16384;
    localparam int EPROM_AW = 14;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [15:0] ERASED_WORD = 16'hffff;

    // Configuration space indices seen by the programmer.
    localparam logic [EPROM_AW-1:0] CFG_PTR_INDEX = 14'h0000;
    localparam logic [EPROM_AW-1:0] CFG_LOW_INDEX = 14'h0006;
    localparam logic [EPROM_AW-1:0] CFG_HIGH_INDEX = 14'h0007;
    localparam logic [2:0] CFG_PTR_RESET = 3'h0;

    // Field positions in the low and high configuration bytes.
    localparam int CFG_ROM_BIT = 0;
    localparam int CFG_RAM_BIT = 1;
    localparam int CFG_SMALL_BIT = 2;
    localparam int CFG_SEC_LSB = 0;

    // Security levels; the field value equals the level number.
    localparam logic [1:0] SEC_LEVEL0 = 2'h0;
    localparam logic [1:0] SEC_LEVEL1 = 2'h1;
    localparam logic [1:0] SEC_LEVEL2 = 2'h2;
    localparam logic [1:0] SEC_LEVEL3 = 2'h3;

    // Scrambling key for encrypted reads; the value is arbitrary.
    localparam logic [7:0] ENCRYPT_KEY = 8'h5a;

    // Normal mode map: the array sits in the top 16 kbytes.
    localparam logic [1:0] ROM_REGION = 2'h3;
    localparam int ROM_WAIT_STATES = 1;

    // Wishbone register offsets and fields.
    localparam logic [3:0] WB_CTRL_ADDR = 4'h0;
    localparam logic [3:0] WB_STATUS_ADDR = 4'h4;
    localparam logic [3:0] WB_CONFIG_ADDR = 4'h8;
    localparam int CTRL_ERASE_BIT = 0;
    localparam int CTRL_RELOAD_BIT = 1;

    typedef enum logic [1:0] {
        RD_PLAIN = 2'b00,
        RD_ENCRYPTED = 2'b01,
        RD_BLANK = 2'b10
    } read_mode_t;

    typedef struct packed {
        logic write_ok;
        read_mode_t prog_read;
        logic runtime_protect;
    } policy_t;

    typedef enum logic [1:0] {
        ST_LOAD = 2'b00,
        ST_IDLE = 2'b01,
        ST_WAIT = 2'b10,
        ST_ERASE = 2'b11
    } ctrl_state_t;

endpackage : eprom_ctrl_pkg

// ### security_policy.sv
// Purpose: Maps the two-bit security level onto read and write privileges.
// Assumes: The level has been loaded from the high configuration byte.
// Notes: Purely combinational; the caller registers every result it drives out.
`timescale 1ns/100ps
module security_policy
    import eprom_ctrl_pkg::*;
(
    // Level in.
    input wire logic [1:0] level_i,
    // Privileges out.
    output policy_t policy_o
);

    always_comb
    begin
        policy_o.write_ok = 1'b0;
        policy_o.prog_read = RD_PLAIN;
        policy_o.runtime_protect = 1'b0;
        unique case (level_i)
            SEC_LEVEL3:
            begin
                policy_o.write_ok = 1'b1;
            end
            SEC_LEVEL2:
            begin
                policy_o.prog_read = RD_PLAIN;
            end
            SEC_LEVEL1:
            begin
                policy_o.prog_read = RD_ENCRYPTED;
                policy_o.runtime_protect = 1'b1;
            end
            SEC_LEVEL0:
            begin
                policy_o.prog_read = RD_BLANK;
                policy_o.runtime_protect = 1'b1;
            end
        endcase
    end

endmodule : security_policy

// ### prog_model.sv
// Purpose: Behavioural external programmer driving the programmer port.
// Assumes: Strobes are one-cycle pulses taken on the rising clock edge.
// Notes: Idle address and data are inverted so stale values never look valid.
`timescale 1ns/100ps
module prog_model
    import eprom_ctrl_pkg::*;
(
    // Clock.
    input wire logic clk_i,
    // Device answers.
    input wire logic [7:0] prog_rdata_i,
    input wire logic prog_rvalid_i,
    // Drives toward the device.
    output logic vpp_o,
    output logic write_o,
    output logic read_o,
    output logic cfg_o,
    output logic [EPROM_AW-1:0] addr_o,
    output logic [7:0] data_o
);
    initial
    begin
        {vpp_o, write_o, read_o, cfg_o, addr_o, data_o} = '0;
    end

    // Supply stays high through every verify read that follows a write.
    task automatic set_vpp(input logic v);
        @(posedge clk_i);
        vpp_o <= v;
        repeat (3) @(posedge clk_i);
    endtask : set_vpp

    task automatic pwrite(input logic c, input logic [EPROM_AW-1:0] a, input logic [7:0] d);
        @(posedge clk_i);
        {write_o, cfg_o, addr_o, data_o} <= {1'b1, c, a, d};
        @(posedge clk_i);
        {write_o, addr_o, data_o} <= {1'b0, ~a, ~d};
    endtask : pwrite

    task automatic pread(input logic c, input logic [EPROM_AW-1:0] a, output logic [7:0] q);
        @(posedge clk_i);
        {read_o, cfg_o, addr_o} <= {1'b1, c, a};
        @(posedge clk_i);
        {read_o, addr_o} <= {1'b0, ~a};
        @(posedge clk_i);
        q = (prog_rvalid_i === 1'b1) ? prog_rdata_i : 8'hxx;
    endtask : pread
endmodule : prog_model

// ### eprom_mode_and_security_control_tb.sv
// Purpose: Self-checking bench for the EPROM mode and security controller.
// Assumes: Erase completion is polled through the status register.
// Notes: Each security level is visited after a fresh erase.
`timescale 1ns/100ps
module eprom_mode_and_security_control_tb
    import eprom_ctrl_pkg::*;
();
    `define CHK(what, exp, got) begin samples_checked++; if ((got) !== (exp)) begin errors++; $display("CHECK FAILED %s expected %h seen %h", what, exp, got); end end

    int errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic strap = 1'b1;
    logic cpu_req = 1'b0;
    logic cpu_op = 1'b0;
    logic cpu_rom = 1'b0;
    logic [15:0] cpu_addr = '0;
    logic [3:0] wb_adr = '0;
    logic [31:0] wb_wdat = '0;
    logic wb_we = 1'b0;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic [31:0] wb_rdat;
    logic [15:0] cpu_rdata;
    logic [13:0] pa;
    logic [7:0] pd, prdata;
    logic wb_ack, vpp, pw, pr, pc, rvalid, cpu_ack, cpu_hit, pmode, ext_prog, alt_fam, ram_en;

    eprom_mode_and_security_control eprom_mode_and_security_control_i (
        .clk_i(clk_i), .rst_i(rst_i), .programming_voltage_pin_i(vpp),
        .external_program_select_i(strap), .prog_write_i(pw), .prog_read_i(pr),
        .prog_cfg_space_i(pc), .prog_addr_i(pa), .prog_data_i(pd), .prog_rdata_o(prdata),
        .prog_rvalid_o(rvalid), .cpu_req_i(cpu_req), .cpu_addr_i(cpu_addr),
        .cpu_operand_i(cpu_op), .cpu_opcode_in_eprom_i(cpu_rom), .cpu_rdata_o(cpu_rdata),
        .cpu_ack_o(cpu_ack), .cpu_hit_o(cpu_hit), .prog_mode_o(pmode),
        .external_program_o(ext_prog), .alt_family_o(alt_fam),
        .upper_ram_bank_enable_o(ram_en), .wb_adr_i(wb_adr), .wb_dat_i(wb_wdat),
        .wb_sel_i(4'hf), .wb_we_i(wb_we), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack));

    prog_model prog_model_i (
        .clk_i(clk_i), .prog_rdata_i(prdata), .prog_rvalid_i(rvalid), .vpp_o(vpp),
        .write_o(pw), .read_o(pr), .cfg_o(pc), .addr_o(pa), .data_o(pd));

    initial
    begin
        forever #4 clk_i = ~clk_i;
    end

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] exp_prog(input logic [1:0] lvl, input logic [13:0] a,
                                            input logic [7:0] d);
        if (lvl == SEC_LEVEL0)
            return ERASED_BYTE;
        if (lvl == SEC_LEVEL1)
            return d ^ ENCRYPT_KEY ^ a[7:0];
        return d;
    endfunction : exp_prog

    function automatic logic [15:0] fetch_exp(input logic [1:0] lvl, input logic op,
                                              input logic rom, input logic [15:0] w);
        return (op && !rom && lvl < SEC_LEVEL2) ? ERASED_WORD : w;
    endfunction : fetch_exp

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : print_verdict

    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 95000)
        begin
            errors++;
            print_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic wb_xfer(input logic we, input logic [3:0] a, input logic [31:0] d,
                           output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_wdat} <= {2'b11, we, a, d};
        @(posedge clk_i);
        while (wb_ack !== 1'b1 && n < 20)
        begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 20)
            errors++;
        q = wb_rdat;
        {wb_cyc, wb_stb, wb_we} <= 3'b000;
    endtask : wb_xfer

    // Issues a control command and waits until the level is loaded and the block is idle.
    task automatic wb_cmd(input int bit_idx);
        logic [31:0] q;
        int n;
        wb_xfer(1'b1, WB_CTRL_ADDR, 32'h1 << bit_idx, q);
        repeat (2) @(posedge clk_i);
        q = '0;
        for (n = 0; n < 8000 && !(q[7] === 1'b1 && q[6:5] === ST_IDLE); n++)
            wb_xfer(1'b0, WB_STATUS_ADDR, '0, q);
        if (n >= 8000)
            errors++;
    endtask : wb_cmd

    task automatic cpu_fetch(input logic [15:0] a, input logic op, input logic rom,
                             input logic hit, input logic [15:0] w);
        int n;
        @(posedge clk_i);
        {cpu_req, cpu_addr, cpu_op, cpu_rom} <= {1'b1, a, op, rom};
        @(posedge clk_i);
        {cpu_req, cpu_addr} <= {1'b0, ~a};
        n = 1;
        while (cpu_ack !== 1'b1 && n < 20)
        begin
            @(posedge clk_i);
            n++;
        end
        `CHK("cpu_wait", 3, n)
        `CHK("cpu_data", w, cpu_rdata)
        `CHK("cpu_hit", hit, cpu_hit)
        @(posedge clk_i);
        `CHK("cpu_ack_pulse", 1'b0, cpu_ack)
    endtask : cpu_fetch

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        logic [31:0] q;
        logic [13:0] a;
        logic [7:0] d0, d1, dx, lo, rd;
        logic [1:0] lvl;
        logic [2:0] ptr;
        void'($urandom(32'h02fb));
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        `CHK("strap_high", 1'b1, ext_prog)
        {rst_i, strap} <= 2'b10;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        strap <= 1'b1;
        repeat (3) @(posedge clk_i);
        `CHK("strap_held", 1'b0, ext_prog)
        for (int i = 3; i >= 0; i--)
        begin
            lvl = 2'(i);
            wb_cmd(CTRL_ERASE_BIT);
            wb_xfer(1'b0, WB_STATUS_ADDR, '0, q);
            `CHK("erased_level", SEC_LEVEL3, q[4:3])
            `CHK("ram_default", 1'b1, ram_en)
            a = (i == 3) ? 14'h3ffe : 14'($urandom) & 14'h3ffe;
            {d0, d1, dx} = 24'($urandom);
            prog_model_i.set_vpp(1'b1);
            `CHK("prog_mode", 1'b1, pmode)
            prog_model_i.pwrite(1'b0, a, d0);
            prog_model_i.pwrite(1'b0, a, dx);
            prog_model_i.pwrite(1'b0, a | 14'h1, d1);
            d0 = d0 & dx;
            prog_model_i.pread(1'b0, a, rd);
            `CHK("and_program", d0, rd)
            prog_model_i.pread(1'b1, CFG_LOW_INDEX, rd);
            `CHK("cfg_erased", ERASED_BYTE, rd)
            prog_model_i.pwrite(1'b1, CFG_PTR_INDEX, 8'h06);
            prog_model_i.pwrite(1'b1, CFG_HIGH_INDEX, {6'h3f, lvl});
            prog_model_i.pread(1'b1, CFG_HIGH_INDEX, rd);
            `CHK("cfg_mismatch", ERASED_BYTE, rd)
            prog_model_i.pwrite(1'b1, CFG_PTR_INDEX, 8'h07);
            prog_model_i.pwrite(1'b1, CFG_HIGH_INDEX, {6'h3f, lvl});
            prog_model_i.pwrite(1'b1, CFG_LOW_INDEX, 8'h00);
            {ptr, lo} = {3'h7, ERASED_BYTE};
            if (i == 3)
            begin
                {ptr, lo} = {3'h6, 8'hf8};
                prog_model_i.pwrite(1'b1, CFG_PTR_INDEX, 8'h06);
                prog_model_i.pwrite(1'b1, CFG_LOW_INDEX, lo);
                // The chip outputs register the new byte one edge after it is written.
                repeat (2) @(posedge clk_i);
                `CHK("alt_family", 1'b1, alt_fam)
                `CHK("ram_disabled", 1'b0, ram_en)
            end
            wb_cmd(CTRL_RELOAD_BIT);
            wb_xfer(1'b0, WB_STATUS_ADDR, '0, q);
            `CHK("level", lvl, q[4:3])
            wb_xfer(1'b0, WB_CONFIG_ADDR, '0, q);
            `CHK("config_reg", {13'h0, ptr, 6'h3f, lvl, lo}, q)
            wb_xfer(1'b1, 4'hc, 32'($urandom), q);
            wb_xfer(1'b0, 4'hc, '0, q);
            `CHK("unmapped", 32'h0, q)
            prog_model_i.pwrite(1'b0, a, 8'h00);
            if (i == 3)
                d0 = 8'h00;
            prog_model_i.pread(1'b0, a, rd);
            `CHK("prog_read", exp_prog(lvl, a, d0), rd)
            prog_model_i.pread(1'b1, CFG_HIGH_INDEX, rd);
            `CHK("cfg_read", {6'h3f, lvl}, rd)
            prog_model_i.set_vpp(1'b0);
            for (int k = 0; k < 3; k++)
                cpu_fetch({2'b11, a}, k != 1, k == 2, a[13] | (i != 3),
                          fetch_exp(lvl, k != 1, k == 2, {d1, d0}));
            if (i == 3)
                cpu_fetch(16'hc000, 1'b0, 1'b0, 1'b0, ERASED_WORD);
        end
        print_verdict();
    end
endmodule : eprom_mode_and_security_control_tb
